// [qpd_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
module qpd_decoder #(
  parameter int         NV_CYCLES = qpd_pkg::NV_STORE_CYCLES,
  parameter logic [3:0] DEV_TYPE  = 4'h9  // type code, value arbitrary
) (
  input  wire logic        clk_i,          // 25 MHz clock
  input  wire logic        rst_i,          // sync reset, active high
  input  wire logic        ce_i,           // clock enable, freezes state
  input  wire logic        scl_i,          // serial clock pin
  input  wire logic        sda_i,          // serial data pin level
  output logic             sda_o,          // serial data drive value
  output logic             sda_oe_o,       // high while pulling data low
  input  wire logic [3:0]  strap_addr_i,   // strapped address pins
  input  wire logic        supplies_ok_i,  // all supplies final
  output logic      [31:0] wiper_counter_o, // wiper per pot, pot0 low
  output logic             nv_busy_o,      // store cycle running
  output logic             stepping_o,     // step mode active
  output logic             ready_o         // power-up recall done
);
  qpd_pkg::qpd_state_t state_q;
  logic [2:0]  scl_q, sda_q;   // [0] sync1, [1] sync2, [2] previous
  logic [1:0]  pg_q;
  logic [3:0]  strap_m_q, strap_s_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shift_q, instr_q, data_q, tx_q;
  logic        oe_q, pend_q, recalled_q;
  logic [7:0]  wiper_q [4];
  logic [31:0] rd_all, wiper_flat, wr_data;
  logic [1:0]  rd_reg;
  logic [3:0]  wr_pot;
  logic        nv_busy, wr_go, accept;

  // instruction legal with its forced-zero fields
  function automatic logic qpd_instr_ok(input logic [7:0] b);
    case (b[7:4])
      qpd_pkg::OP_RD_WIPER, qpd_pkg::OP_WR_WIPER, qpd_pkg::OP_STEP:
        return b[3:2] == 2'h0;
      qpd_pkg::OP_RD_STORED, qpd_pkg::OP_WR_STORED,
      qpd_pkg::OP_XFR_TO_WIPER, qpd_pkg::OP_XFR_TO_STORED:
        return 1'b1;
      qpd_pkg::OP_GXFR_TO_WIPER, qpd_pkg::OP_GXFR_TO_STORED:
        return b[1:0] == 2'h0;
      default:
        return 1'b0;
    endcase
  endfunction

  // pin synchronisers, two flops before any logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q     <= 3'h7;
      sda_q     <= 3'h7;
      pg_q      <= 2'h0;
      strap_m_q <= 4'h0;
      strap_s_q <= 4'h0;
    end
    else if (ce_i)
    begin
      scl_q     <= {scl_q[1:0], scl_i};
      sda_q     <= {sda_q[1:0], sda_i};
      pg_q      <= {pg_q[0], supplies_ok_i};
      strap_m_q <= strap_addr_i;
      strap_s_q <= strap_m_q;
    end
  end

  // bus events from synchronised levels
  wire scl_s    = scl_q[1];
  wire sda_s    = sda_q[1];
  wire pg_s     = pg_q[1];
  wire scl_rise = scl_s & ~scl_q[2];
  wire scl_fall = ~scl_s & scl_q[2];
  wire start_ev = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
  wire stop_ev  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;

  // latched instruction fields
  wire [3:0] op   = instr_q[7:4];
  wire [1:0] rsel = instr_q[3:2];
  wire [1:0] psel = instr_q[1:0];
  wire [7:0] sel_wiper = wiper_q[psel];

  // byte returned by a read, chosen from the incoming instruction
  wire [7:0] rd_byte = (shift_q[7:4] == qpd_pkg::OP_RD_WIPER) ?
                       wiper_q[shift_q[1:0]] :
                       rd_all[{shift_q[1:0], 3'b000} +: 8];

  // acknowledge decision per byte slot
  wire addr_hit = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:0] == strap_s_q);
  assign accept = (state_q == qpd_pkg::ST_ADDR)  ? addr_hit && !nv_busy && recalled_q :
                  (state_q == qpd_pkg::ST_INSTR) ? qpd_instr_ok(shift_q) :
                  (state_q == qpd_pkg::ST_WDATA);

  // protocol engine: address, instruction, data, ack slots
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= qpd_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
      data_q  <= 8'h00;
      tx_q    <= 8'h00;
      oe_q    <= 1'b0;
      pend_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_ev)
      begin
        state_q <= qpd_pkg::ST_ADDR;
        cnt_q   <= 4'h0;
        oe_q    <= 1'b0;
        pend_q  <= 1'b0;
      end
      else if (stop_ev)
      begin
        state_q <= qpd_pkg::ST_IDLE;
        oe_q    <= 1'b0;
        pend_q  <= 1'b0;
      end
      else
        case (state_q)
          qpd_pkg::ST_ADDR, qpd_pkg::ST_INSTR, qpd_pkg::ST_WDATA:
          begin
            if (scl_rise)
            begin
              if (cnt_q < qpd_pkg::CNT_ACK)
                shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == qpd_pkg::CNT_ACK)
            begin
              if (accept)
                oe_q <= 1'b1;
              else
                state_q <= qpd_pkg::ST_IDLE;
            end
            else if (scl_fall && cnt_q == qpd_pkg::CNT_DONE)
            begin
              oe_q  <= 1'b0;
              cnt_q <= 4'h0;
              if (state_q == qpd_pkg::ST_ADDR)
                state_q <= qpd_pkg::ST_INSTR;
              else if (state_q == qpd_pkg::ST_WDATA)
              begin
                data_q  <= shift_q;
                pend_q  <= 1'b1;
                state_q <= qpd_pkg::ST_HOLD;
              end
              else
              begin
                instr_q <= shift_q;
                case (shift_q[7:4])
                  qpd_pkg::OP_RD_WIPER, qpd_pkg::OP_RD_STORED:
                  begin
                    tx_q    <= rd_byte;
                    oe_q    <= ~rd_byte[7];
                    state_q <= qpd_pkg::ST_RDATA;
                  end
                  qpd_pkg::OP_WR_WIPER, qpd_pkg::OP_WR_STORED:
                    state_q <= qpd_pkg::ST_WDATA;
                  qpd_pkg::OP_STEP:
                    state_q <= qpd_pkg::ST_STEP;
                  default:
                  begin
                    pend_q  <= 1'b1;
                    state_q <= qpd_pkg::ST_HOLD;
                  end
                endcase
              end
            end
          end
          qpd_pkg::ST_RDATA:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall && cnt_q < qpd_pkg::CNT_ACK)
            begin
              tx_q <= {tx_q[6:0], 1'b0};
              oe_q <= ~tx_q[6];
            end
            else if (scl_fall)
            begin
              oe_q    <= 1'b0;  // master acknowledge slot
              state_q <= qpd_pkg::ST_HOLD;
            end
          end
          default:
            state_q <= state_q;
        endcase
    end
  end

  // store request at the stop that ends a store frame
  assign wr_go  = stop_ev && pend_q &&
                  (op == qpd_pkg::OP_WR_STORED || op == qpd_pkg::OP_XFR_TO_STORED ||
                   op == qpd_pkg::OP_GXFR_TO_STORED);
  assign wr_pot = (op == qpd_pkg::OP_GXFR_TO_STORED) ? 4'hf : 4'(4'h1 << psel);
  assign wiper_flat = {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};
  assign wr_data    = (op == qpd_pkg::OP_WR_STORED) ? {4{data_q}} : wiper_flat;
  assign rd_reg     = !recalled_q ? qpd_pkg::RECALL_REG :
                      (state_q == qpd_pkg::ST_INSTR) ? shift_q[3:2] : rsel;

  qpd_store #(
    .NV_CYCLES (NV_CYCLES)
  ) u_store (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wr_i      (wr_go),
    .wr_pot_i  (wr_pot),
    .wr_reg_i  (rsel),
    .wr_data_i (wr_data),
    .rd_reg_i  (rd_reg),
    .rd_data_o (rd_all),
    .busy_o    (nv_busy)
  );

  // wiper counters: recall, stepping, frame results
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int p = 0; p < 4; p++)
        wiper_q[p] <= qpd_pkg::WIPER_RESET;
      recalled_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!recalled_q)
      begin
        if (pg_s)
        begin
          for (int p = 0; p < 4; p++)
            wiper_q[p] <= rd_all[8*p +: 8];
          recalled_q <= 1'b1;
        end
      end
      else if (state_q == qpd_pkg::ST_STEP && scl_rise)
      begin
        if (sda_s && sel_wiper != 8'hff)
          wiper_q[psel] <= sel_wiper + 8'h01;
        else if (!sda_s && sel_wiper != 8'h00)
          wiper_q[psel] <= sel_wiper - 8'h01;
      end
      else if (stop_ev && pend_q)
        case (op)
          qpd_pkg::OP_WR_WIPER:
            wiper_q[psel] <= data_q;
          qpd_pkg::OP_XFR_TO_WIPER:
            wiper_q[psel] <= rd_all[{psel, 3'b000} +: 8];
          qpd_pkg::OP_GXFR_TO_WIPER:
            for (int p = 0; p < 4; p++)
              wiper_q[p] <= rd_all[8*p +: 8];
          default:
            wiper_q[psel] <= sel_wiper;
        endcase
    end
  end

  // outputs
  assign sda_o           = 1'b0;
  assign sda_oe_o        = oe_q;
  assign wiper_counter_o = wiper_flat;
  assign nv_busy_o       = nv_busy;
  assign stepping_o      = (state_q == qpd_pkg::ST_STEP);
  assign ready_o         = recalled_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_MATCH: assert property (
    oe_q && state_q == qpd_pkg::ST_ADDR |-> addr_hit) else $error("ack on wrong address");
  AST_ACK_BUSY: assert property (
    oe_q && state_q == qpd_pkg::ST_ADDR |-> !nv_busy) else $error("ack while storing");
  AST_WR_WIPER: assert property (
    ce_i && stop_ev && pend_q && op == qpd_pkg::OP_WR_WIPER
    |=> wiper_q[$past(psel)] == $past(data_q)) else $error("wiper write lost");
  AST_WR_STORED: assert property (
    ce_i && stop_ev && pend_q && op == qpd_pkg::OP_WR_STORED && !nv_busy
    |=> nv_busy ##1 nv_busy) else $error("stored write did not start");
  AST_XFR_STORE: assert property (
    ce_i && stop_ev && pend_q && op == qpd_pkg::OP_XFR_TO_STORED |-> wr_go && wr_pot == 4'(4'h1 << psel))
    else $error("transfer store wrong pot");
  AST_GXFR_STORE: assert property (
    ce_i && wr_go && op == qpd_pkg::OP_GXFR_TO_STORED |-> wr_pot == 4'hf && wr_data == wiper_flat)
    else $error("global store not all pots");
  AST_XFR_WIPER: assert property (
    ce_i && stop_ev && pend_q && op == qpd_pkg::OP_XFR_TO_WIPER
    |=> wiper_q[$past(psel)] == $past(rd_all[{psel, 3'b000} +: 8])) else $error("transfer lost");
  AST_GXFR_WIPER: assert property (
    ce_i && stop_ev && pend_q && op == qpd_pkg::OP_GXFR_TO_WIPER
    |=> wiper_flat == $past(rd_all)) else $error("global transfer lost");
  AST_STEP_UP: assert property (
    ce_i && recalled_q && state_q == qpd_pkg::ST_STEP && scl_rise && sda_s && sel_wiper != 8'hff
    |=> wiper_q[$past(psel)] == $past(sel_wiper) + 8'h01) else $error("step up missed");
  AST_STEP_DN: assert property (
    ce_i && recalled_q && state_q == qpd_pkg::ST_STEP && scl_rise && !sda_s && sel_wiper != 8'h00
    |=> wiper_q[$past(psel)] == $past(sel_wiper) - 8'h01) else $error("step down missed");
  AST_RECALL: assert property (
    ce_i && !recalled_q && pg_s |=> recalled_q && wiper_flat == $past(rd_all))
    else $error("recall wrong");
  AST_NO_EARLY: assert property (
    $rose(recalled_q) |-> $past(pg_s)) else $error("recall before supplies");

  COV_STEP: cover property (state_q == qpd_pkg::ST_STEP && scl_rise);
  COV_STORE: cover property (wr_go && ce_i);
  COV_READ: cover property (state_q == qpd_pkg::ST_RDATA && scl_fall);
  COV_REFUSE: cover property (state_q == qpd_pkg::ST_ADDR && scl_fall && cnt_q == 4'h8 && !accept);
endmodule
`default_nettype wire

// [qpd_store.sv]
`timescale 1ns/10ps
`default_nettype none
package qpd_pkg;
  // instruction opcodes, upper nibble of the instruction byte
  localparam logic [3:0] OP_RD_WIPER       = 4'h9;
  localparam logic [3:0] OP_WR_WIPER       = 4'ha;
  localparam logic [3:0] OP_RD_STORED      = 4'hb;
  localparam logic [3:0] OP_WR_STORED      = 4'hc;
  localparam logic [3:0] OP_XFR_TO_WIPER   = 4'hd;
  localparam logic [3:0] OP_XFR_TO_STORED  = 4'he;
  localparam logic [3:0] OP_GXFR_TO_WIPER  = 4'h1;
  localparam logic [3:0] OP_GXFR_TO_STORED = 4'h8;
  localparam logic [3:0] OP_STEP           = 4'h2;
  // bit counter marks inside a byte slot
  localparam logic [3:0] CNT_ACK           = 4'h8;
  localparam logic [3:0] CNT_DONE          = 4'h9;
  // values after reset
  localparam logic [7:0] WIPER_RESET       = 8'h00;
  localparam logic [7:0] STORED_RESET      = 8'h00;
  localparam logic [1:0] RECALL_REG        = 2'h0;
  // nonvolatile write time, longest time so rounded down
  localparam int         CLK_HZ            = 25_000_000;
  localparam int         NV_STORE_TIME_MS  = 10;
  localparam int         NV_STORE_CYCLES   = NV_STORE_TIME_MS * (CLK_HZ / 1000);
  // protocol states, gray along address, instruction, data
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INSTR = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_STEP  = 3'b111,
    ST_HOLD  = 3'b101
  } qpd_state_t;
endpackage

module qpd_store #(
  parameter int NV_CYCLES = qpd_pkg::NV_STORE_CYCLES
) (
  input  wire logic        clk_i,      // 25 MHz clock
  input  wire logic        rst_i,      // sync reset, active high
  input  wire logic        ce_i,       // clock enable
  input  wire logic        wr_i,       // start a store cycle
  input  wire logic [3:0]  wr_pot_i,   // pots written
  input  wire logic [1:0]  wr_reg_i,   // stored setting index
  input  wire logic [31:0] wr_data_i,  // byte per pot
  input  wire logic [1:0]  rd_reg_i,   // index read for all pots
  output logic      [31:0] rd_data_o,  // byte per pot
  output logic             busy_o      // store cycle running
);
  localparam int CW = $clog2(NV_CYCLES + 1);

  // refuse a store time the counter cannot hold
  if (NV_CYCLES < 1 || NV_CYCLES > 16777215)
  begin : g_bad_cycles
    $error("qpd_store: NV_CYCLES out of range");
  end

  logic [7:0]    mem_q [16];
  logic [CW-1:0] cnt_q;

  // storage array and store-cycle timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 16; i++)
        mem_q[i] <= qpd_pkg::STORED_RESET;
      cnt_q <= '0;
    end
    else if (ce_i)
    begin
      if (wr_i && !busy_o)
      begin
        for (int p = 0; p < 4; p++)
          if (wr_pot_i[p])
            mem_q[{wr_reg_i, p[1:0]}] <= wr_data_i[8*p +: 8];
        cnt_q <= CW'(NV_CYCLES);
      end
      else if (cnt_q != '0)
        cnt_q <= cnt_q - CW'(1);
    end
  end

  assign busy_o = (cnt_q != '0);

  // one read port per pot at the same index
  for (genvar g = 0; g < 4; g++)
  begin : g_rd
    assign rd_data_o[8*g +: 8] = mem_q[{rd_reg_i, 2'(g)}];
  end

  AST_NV_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= CW'(NV_CYCLES)) else $error("store timer beyond limit");
  AST_NV_START: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && !busy_o && ce_i |=> busy_o) else $error("store cycle did not start");
endmodule
`default_nettype wire

// [qpd_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module qpd_master_model (
  input  wire logic clk_i,      // bench clock
  input  wire logic sda_i,      // resolved data wire
  output logic      scl_o,      // serial clock to device
  output logic      sda_pull_o  // high pulls data wire low
);
  // bus idle: clock high, data released to the pull-up
  initial
  begin
    scl_o <= 1'b1;
    sda_pull_o <= 1'b0;
  end
  // wait whole bench clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one clock: data set 1 clk after fall, 4 clk low, 4 clk high
  task automatic pulse(input logic b, output logic s);
    sda_pull_o <= ~b;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    s = sda_i;
    tick(2);
    scl_o <= 1'b0;
    tick(1);
  endtask
  // data falls while clock high
  task automatic start_cond();
    sda_pull_o <= 1'b0;
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(1);
  endtask
  // data rises while clock high, then bus free time
  task automatic stop_cond();
    sda_pull_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b0;
    tick(8);
  endtask
  // msb first, ninth clock samples the device acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask
  // data released while device shifts, last byte answered high
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(last, s);
  endtask
endmodule
`default_nettype wire

// [qpd_decoder_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module qpd_decoder_tb;
  localparam int         NV    = 200;    // shortened store time
  localparam logic [3:0] TYP   = 4'h6;   // type code, value arbitrary
  localparam logic [3:0] STRAP = 4'ha;   // strapped address
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        sup_ok = 1'b0;
  logic        ce     = 1'b1;
  logic [3:0]  strap  = STRAP;
  logic        scl;
  logic        pull;
  logic        sda_drv;
  logic        oe;
  logic [31:0] wiper;
  logic        nv_busy;
  logic        stepping;
  logic        ready;
  int          checked = 0;
  int          fail_count = 0;
  int          cycles = 0;
  // open-drain wire with pull-up
  wire sda_w = (oe ? sda_drv : 1'b1) & ~pull;

  always #20 clk = ~clk;

  qpd_decoder #(.NV_CYCLES(NV), .DEV_TYPE(TYP)) dut_u (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_drv), .sda_oe_o(oe), .strap_addr_i(strap), .supplies_ok_i(sup_ok),
    .wiper_counter_o(wiper), .nv_busy_o(nv_busy), .stepping_o(stepping), .ready_o(ready)
  );
  qpd_master_model m_u (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame: kind 0 two bytes, 1 write byte d, 2 read byte expecting d
  task automatic cmd(input logic [3:0] op, input logic [1:0] r, input logic [1:0] p,
                     input int kind, input logic [7:0] d, input logic exp_ack);
    logic       a;
    logic [7:0] rb;
    m_u.start_cond();
    m_u.send_byte({TYP, STRAP}, a);
    check("address ack", 32'(a), 32'(exp_ack));
    if (a)
    begin
      m_u.send_byte({op, r, p}, a);
      check("instruction ack", 32'(a), 32'h1);
      if (kind == 1)
        m_u.send_byte(d, a);
      if (kind == 2)
        m_u.recv_byte(1'b1, rb);
      if (kind == 2)
        check("read byte", 32'(rb), 32'(d));
    end
    m_u.stop_cond();
  endtask
  // bounded wait for the store cycle to end
  task automatic wait_store();
    for (int n = 0; n < NV + 10 && nv_busy !== 1'b0; n++)
      @(posedge clk);
    check("store done", 32'(nv_busy), 32'h0);
  endtask
  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      summarize();
    end
  end

  // main sequence
  initial
  begin
    logic a;
    logic s;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    check("ready early", 32'(ready), 32'h0);
    cmd(qpd_pkg::OP_WR_WIPER, 2'h0, 2'h0, 1, 8'h77, 1'b0);
    ce <= 1'b0;
    sup_ok <= 1'b1;
    repeat (8) @(posedge clk);
    check("frozen ready", 32'(ready), 32'h0);
    ce <= 1'b1;
    for (int n = 0; n < 10 && ready !== 1'b1; n++)
      @(posedge clk);
    check("ready", 32'(ready), 32'h1);
    check("recall", wiper, 32'h0);
    $display("power-up test done");
    strap <= 4'h5;
    repeat (4) @(posedge clk);
    cmd(qpd_pkg::OP_WR_WIPER, 2'h0, 2'h0, 1, 8'h77, 1'b0);
    strap <= STRAP;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++)
      cmd(qpd_pkg::OP_WR_WIPER, 2'h0, 2'(i), 1, 8'(8'h11 * (i + 1)), 1'b1);
    check("wipers", wiper, 32'h44332211);
    cmd(qpd_pkg::OP_RD_WIPER, 2'h0, 2'h2, 2, 8'h33, 1'b1);
    $display("wiper test done");
    cmd(qpd_pkg::OP_WR_STORED, 2'h2, 2'h3, 1, 8'hc3, 1'b1);
    check("busy", 32'(nv_busy), 32'h1);
    cmd(qpd_pkg::OP_RD_STORED, 2'h2, 2'h3, 2, 8'hc3, 1'b0);
    wait_store();
    cmd(qpd_pkg::OP_RD_STORED, 2'h2, 2'h3, 2, 8'hc3, 1'b1);
    cmd(qpd_pkg::OP_XFR_TO_STORED, 2'h1, 2'h1, 0, 8'h00, 1'b1);
    wait_store();
    cmd(qpd_pkg::OP_RD_STORED, 2'h1, 2'h1, 2, 8'h22, 1'b1);
    cmd(qpd_pkg::OP_XFR_TO_WIPER, 2'h2, 2'h3, 0, 8'h00, 1'b1);
    check("wiper from store", wiper, 32'hc3332211);
    $display("store test done");
    cmd(qpd_pkg::OP_GXFR_TO_STORED, 2'h3, 2'h0, 0, 8'h00, 1'b1);
    wait_store();
    cmd(qpd_pkg::OP_RD_STORED, 2'h3, 2'h2, 2, 8'h33, 1'b1);
    cmd(qpd_pkg::OP_WR_WIPER, 2'h0, 2'h0, 1, 8'h99, 1'b1);
    cmd(qpd_pkg::OP_GXFR_TO_WIPER, 2'h3, 2'h0, 0, 8'h00, 1'b1);
    check("global recall", wiper, 32'hc3332211);
    $display("global test done");
    m_u.start_cond();
    m_u.send_byte({TYP, STRAP}, a);
    m_u.send_byte({qpd_pkg::OP_WR_WIPER, 4'h4}, a);
    check("bad instruction ack", 32'(a), 32'h0);
    m_u.stop_cond();
    check("wipers kept", wiper, 32'hc3332211);
    m_u.start_cond();
    m_u.send_byte({TYP, STRAP}, a);
    m_u.send_byte({qpd_pkg::OP_STEP, 4'h0}, a);
    check("step ack", 32'(a), 32'h1);
    for (int i = 0; i < 4; i++)
      m_u.pulse(i < 3, s);
    check("stepping", 32'(stepping), 32'h1);
    m_u.stop_cond();
    check("stepping end", 32'(stepping), 32'h0);
    check("step wiper", 32'(wiper[7:0]), 32'h12);
    $display("step test done");
    summarize();
  end
endmodule
`default_nettype wire
